// file: logic/ett_map.svh
// Register offsets, field positions and reset values of the 8-bit timer/counter.
// Assumes inclusion by the timer module and the bench only.
`ifndef ETT_MAP_SVH
`define ETT_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ETT_OFF_CTRL 8'h00
`define ETT_OFF_CNT 8'h04
`define ETT_OFF_CMP 8'h08
`define ETT_OFF_MASK 8'h0C
`define ETT_OFF_FLAGS 8'h10
`define ETT_OFF_PORT 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ETT_BIT_FORCE 7
`define ETT_BIT_WGM_LO 6
`define ETT_BIT_COM_HI 5
`define ETT_BIT_COM_LO 4
`define ETT_BIT_WGM_HI 3
`define ETT_BIT_CMP_FLAG 1
`define ETT_BIT_OVF_FLAG 0
`define ETT_BIT_PORT_DIR 0
`define ETT_BIT_PORT_VAL 1
`define ETT_BIT_GIE 2

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define ETT_RST_BYTE 8'h00
`define ETT_MAX 8'hFF
`define ETT_BOTTOM 8'h00
`define ETT_PRESC_W 10

`endif

// file: logic/ett_pkg.sv
// Types shared by the 8-bit timer/counter.
// Assumes nothing beyond the map header.
package ett_pkg;

  typedef enum logic [1:0] {
    ETT_NORMAL = 2'b00,
    ETT_PHASE = 2'b01,
    ETT_CLEAR = 2'b10,
    ETT_FAST = 2'b11
  } ett_mode_e;

  typedef struct packed {
    logic [1:0] compare_output_sel;
    logic [2:0] clock_source_sel;
    ett_mode_e waveform_mode_sel;
  } ett_ctrl_s;

  typedef struct packed {
    logic compare_flag;
    logic overflow_flag;
  } ett_flags_s;

endpackage

// file: logic/ett_timer.sv
// 8-bit timer/counter with waveform output, behind a classic Wishbone slave.
// Assumes ext_count_pin and all bus inputs are synchronous to clk.
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "ett_map.svh"

// Functional notes
// (R01) Counter synchronous; tick is only an enable
// (R02) Force strobe acts only in non-PWM modes
// (R03) Software keeps force bit zero in PWM
// (R04) Force strobe applies compare-output action now
// (R05) Force sets no flag, clears no counter
// (R06) Force bit reads back as zero
// (R07) Mode bits 6 and 3 select mode
// (R08) TOP is FF, or compare in clear mode
// (R09) Compare update timing and overflow point
// (R10) Clear mode clears counter, sets flag on match
// (R11) Output overrides pin; driver needs direction bit
// (R12) Non-PWM: toggle, clear or set on match
// (R13) Fast PWM: match action, opposite at bottom
// (R14) Fast PWM compare at TOP suppresses match
// (R15) Phase PWM: up and down match actions
// (R16) Phase PWM compare at TOP acts at TOP
// (R17) Clock select stop, direct, prescaled taps
// (R18) Select 110 falling, 111 rising external edge
// (R19) External pin counts even as output
// (R20) Counter register readable and writable
// (R21) Counter write blocks next tick's match
// (R22) Compare continuously with counter
// (R23) Flags cleared by vector or writing one
// (R24) Interrupt needs global, enable and flag
// (R25) Phase PWM overflow at bottom reversal
// (R26) All registers reset to zero
// (R27) Mask bit 1 compare, bit 0 overflow
module ett_timer
  import ett_pkg::*;
#(
  parameter int PRESC_W = `ETT_PRESC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic ext_count_pin,
  input wire logic cmp_vector_taken,
  input wire logic ovf_vector_taken,
  output logic waveform_out_pin,
  output logic waveform_out_oe,
  output logic compare_irq,
  output logic overflow_irq
);

  initial begin
    if (PRESC_W < 10) begin
      $error("PRESC_W must cover the divide-by-1024 tap");
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ett_ctrl_s ctrl_r;
  logic [7:0] counter_r;
  logic [7:0] compare_r;
  logic [7:0] compare_buf_r;
  logic [7:0] mask_r;
  ett_flags_s flags_r;
  logic port_dir_r;
  logic port_val_r;
  logic gie_r;
  logic wave_r;
  logic down_r;
  logic block_r;
  logic ext_q_r;
  logic [PRESC_W-1:0] presc_r;
  logic ack_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic req;
  logic wr0;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_mask;
  logic wr_flags;
  logic wr_port;
  logic force_req;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr0 = req && wb_we_i && wb_sel_i[0];
  assign wr_ctrl = wr0 && (wb_adr_i == `ETT_OFF_CTRL);
  assign wr_cnt = wr0 && (wb_adr_i == `ETT_OFF_CNT);
  assign wr_cmp = wr0 && (wb_adr_i == `ETT_OFF_CMP);
  assign wr_mask = wr0 && (wb_adr_i == `ETT_OFF_MASK);
  assign wr_flags = wr0 && (wb_adr_i == `ETT_OFF_FLAGS);
  assign wr_port = wr0 && (wb_adr_i == `ETT_OFF_PORT);

  // (R07) Mode bit positions
  ett_mode_e mode_wr;
  assign mode_wr = ett_mode_e'({wb_dat_i[`ETT_BIT_WGM_HI], wb_dat_i[`ETT_BIT_WGM_LO]});
  ett_mode_e mode;
  assign mode = ctrl_r.waveform_mode_sel;

  // (R02) Force gated by non-PWM mode
  assign force_req = wr_ctrl && wb_dat_i[`ETT_BIT_FORCE] && !mode_wr[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end
  assign wb_ack_o = ack_r;

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  function automatic logic tap_hit(input logic [PRESC_W-1:0] p, input int bits);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((1 << bits) - 1);
    tap_hit = ((p & m) == m);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q_r <= 1'b0;
    end else begin
      ext_q_r <= ext_count_pin;
    end
  end

  logic tick;
  // (R17) Clock source select
  // (R18) External edge choice
  // (R19) Pin direction not consulted
  always_comb begin
    case (ctrl_r.clock_source_sel)
      3'b000: tick = 1'b0;
      3'b001: tick = 1'b1;
      3'b010: tick = tap_hit(presc_r, 3);
      3'b011: tick = tap_hit(presc_r, 6);
      3'b100: tick = tap_hit(presc_r, 8);
      3'b101: tick = tap_hit(presc_r, 10);
      3'b110: tick = ext_q_r && !ext_count_pin;
      3'b111: tick = !ext_q_r && ext_count_pin;
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Compare and TOP
  // ----------------------------------------
  logic [7:0] top;
  logic match;
  logic at_top;
  logic at_bottom;
  // (R08) TOP selection
  assign top = (mode == ETT_CLEAR) ? compare_r : `ETT_MAX;
  // (R22) Continuous compare
  // (R21) Write-blocked match
  assign match = (counter_r == compare_r) && tick && !block_r;
  assign at_top = (counter_r == top);
  assign at_bottom = (counter_r == `ETT_BOTTOM);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // (R01) Tick as enable only
  // (R20) Software counter access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_r <= `ETT_RST_BYTE;
    end else if (wr_cnt) begin
      counter_r <= wb_dat_i[7:0];
    end else if (tick) begin
      case (mode)
        ETT_PHASE: begin
          if (down_r) begin
            counter_r <= at_bottom ? counter_r + 1'b1 : counter_r - 1'b1;
          end else begin
            counter_r <= at_top ? counter_r - 1'b1 : counter_r + 1'b1;
          end
        end
        // (R10) Clear on match
        ETT_CLEAR: counter_r <= at_top ? `ETT_BOTTOM : counter_r + 1'b1;
        default: counter_r <= counter_r + 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      down_r <= 1'b0;
    end else if (mode != ETT_PHASE) begin
      down_r <= 1'b0;
    end else if (tick && !wr_cnt) begin
      if (!down_r && at_top) begin
        down_r <= 1'b1;
      end else if (down_r && at_bottom) begin
        down_r <= 1'b0;
      end
    end
  end

  // (R21) Block match after write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      block_r <= 1'b1;
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Compare register with buffering
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_buf_r <= `ETT_RST_BYTE;
    end else if (wr_cmp) begin
      compare_buf_r <= wb_dat_i[7:0];
    end
  end

  // (R09) Update point per mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_r <= `ETT_RST_BYTE;
    end else if (!mode[0]) begin
      compare_r <= wr_cmp ? wb_dat_i[7:0] : compare_buf_r;
    end else if (tick && at_top && (mode == ETT_PHASE) && !down_r) begin
      compare_r <= compare_buf_r;
    end else if (tick && at_top && (mode == ETT_FAST)) begin
      compare_r <= compare_buf_r;
    end
  end

  // ----------------------------------------
  // Control, mask, port registers
  // ----------------------------------------
  // (R26) Reset to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= '0;
    end else if (wr_ctrl) begin
      ctrl_r.waveform_mode_sel <= mode_wr;
      ctrl_r.compare_output_sel <= wb_dat_i[`ETT_BIT_COM_HI:`ETT_BIT_COM_LO];
      ctrl_r.clock_source_sel <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `ETT_RST_BYTE;
    end else if (wr_mask) begin
      mask_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_dir_r <= 1'b0;
      port_val_r <= 1'b0;
      gie_r <= 1'b0;
    end else if (wr_port) begin
      port_dir_r <= wb_dat_i[`ETT_BIT_PORT_DIR];
      port_val_r <= wb_dat_i[`ETT_BIT_PORT_VAL];
      gie_r <= wb_dat_i[`ETT_BIT_GIE];
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic ovf_evt;
  // (R09) Overflow at MAX
  // (R25) Phase overflow at bottom
  assign ovf_evt = tick && !wr_cnt &&
                   ((mode == ETT_PHASE) ? (down_r && at_bottom) : (counter_r == `ETT_MAX));

  // (R23) Clear by vector or one
  // (R05) Force not a flag source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      if (match) begin
        flags_r.compare_flag <= 1'b1;
      end else if (cmp_vector_taken || (wr_flags && wb_dat_i[`ETT_BIT_CMP_FLAG])) begin
        flags_r.compare_flag <= 1'b0;
      end
      if (ovf_evt) begin
        flags_r.overflow_flag <= 1'b1;
      end else if (ovf_vector_taken || (wr_flags && wb_dat_i[`ETT_BIT_OVF_FLAG])) begin
        flags_r.overflow_flag <= 1'b0;
      end
    end
  end

  // (R24) Interrupt gating
  // (R27) Mask bit positions
  assign compare_irq = gie_r && mask_r[1] && flags_r.compare_flag;
  assign overflow_irq = gie_r && mask_r[0] && flags_r.overflow_flag;

  // ----------------------------------------
  // Waveform output
  // ----------------------------------------
  logic [1:0] com;
  logic cmp_is_top;
  assign com = ctrl_r.compare_output_sel;
  assign cmp_is_top = (compare_r == `ETT_MAX) && com[1];

  // (R04) Forced action by output mode
  // (R12) Non-PWM actions
  // (R13) Fast PWM actions
  // (R14) Fast PWM top special
  // (R15) Phase PWM actions
  // (R16) Phase PWM top special
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_r <= 1'b0;
    end else if (force_req || (match && !mode[0])) begin
      case (force_req ? wb_dat_i[`ETT_BIT_COM_HI:`ETT_BIT_COM_LO] : com)
        2'b01: wave_r <= !wave_r;
        2'b10: wave_r <= 1'b0;
        2'b11: wave_r <= 1'b1;
        default: wave_r <= wave_r;
      endcase
    end else if (mode == ETT_FAST && com[1] && tick) begin
      if (counter_r == `ETT_MAX) begin
        wave_r <= !com[0];
      end else if (match && !cmp_is_top) begin
        wave_r <= com[0];
      end
    end else if (mode == ETT_PHASE && com[1] && tick) begin
      if (cmp_is_top) begin
        if (at_top && !down_r) begin
          wave_r <= !com[0];
        end
      end else if (match) begin
        wave_r <= down_r ? !com[0] : com[0];
      end
    end
  end

  // (R11) Pin override and driver enable
  assign waveform_out_pin = (com != 2'b00) ? wave_r : port_val_r;
  assign waveform_out_oe = port_dir_r;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // (R06) Force bit reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      case (wb_adr_i)
        `ETT_OFF_CTRL: wb_dat_o <= {24'h00_0000, 1'b0, mode[0], com, mode[1], ctrl_r.clock_source_sel};
        `ETT_OFF_CNT: wb_dat_o <= {24'h00_0000, counter_r};
        `ETT_OFF_CMP: wb_dat_o <= {24'h00_0000, compare_buf_r};
        `ETT_OFF_MASK: wb_dat_o <= {24'h00_0000, mask_r};
        `ETT_OFF_FLAGS: wb_dat_o <= {30'h0000_0000, flags_r.compare_flag, flags_r.overflow_flag};
        `ETT_OFF_PORT: wb_dat_o <= {29'h0000_0000, gie_r, port_val_r, port_dir_r};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_force_no_flag: assert property (@(posedge clk) disable iff (!rst_n) // (R05)
    (force_req && !match && !flags_r.compare_flag && !cmp_vector_taken) |=> !flags_r.compare_flag)
    else $error("forced compare set the flag");

  a_force_pwm_ignored: assert property (@(posedge clk) disable iff (!rst_n) // (R02)
    (wr_ctrl && wb_dat_i[`ETT_BIT_FORCE] && mode_wr[0] && !tick) |=> $stable(wave_r))
    else $error("force accepted in PWM mode");

  a_force_set: assert property (@(posedge clk) disable iff (!rst_n) // (R04)
    (force_req && wb_dat_i[`ETT_BIT_COM_HI:`ETT_BIT_COM_LO] == 2'b11) |=> wave_r)
    else $error("forced set did not set output");

  a_clear_wrap: assert property (@(posedge clk) disable iff (!rst_n) // (R10)
    (mode == ETT_CLEAR && match && !wr_cnt && !wr_ctrl) |=> (counter_r == 8'h00 && flags_r.compare_flag))
    else $error("clear mode did not clear on match");

  a_write_blocks: assert property (@(posedge clk) disable iff (!rst_n) // (R21)
    wr_cnt |=> !match)
    else $error("match after counter write");

  a_ovf_max: assert property (@(posedge clk) disable iff (!rst_n) // (R09)
    (tick && mode == ETT_NORMAL && counter_r == 8'hFF && !wr_cnt && !wr_ctrl) |=> flags_r.overflow_flag)
    else $error("overflow flag missed at MAX");

  a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n) // (R23)
    (wr_flags && wb_dat_i[1] && !match) |=> !flags_r.compare_flag)
    else $error("compare flag not cleared by one");

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n) // (R24)
    compare_irq |-> (gie_r && mask_r[1] && flags_r.compare_flag))
    else $error("compare irq without enables");

  a_stopped: assert property (@(posedge clk) disable iff (!rst_n) // (R17)
    (ctrl_r.clock_source_sel == 3'b000 && !wr_cnt && !wr_ctrl) |=> $stable(counter_r))
    else $error("counter moved while stopped");

  a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n) // (R06)
    (ack_r && $past(wb_adr_i) == 8'h00 && !$past(wb_we_i)) |-> !wb_dat_o[7])
    else $error("force bit read as one");

endmodule

// file: dv/ett_event_src.sv
// External event source driving the count input pin.
// Assumes the bench pulses start for one clock with a count of pulses.
`timescale 1ns/1ps
module ett_event_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] edges,
  output logic pin,
  output logic busy
);
  logic [8:0] left_r;
  logic ph_r;
  // ----------------------------------------
  // Pulse generator
  // ----------------------------------------
  // Each level held two clocks, idle low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= '0;
      ph_r <= 1'b0;
      pin <= 1'b0;
    end else if (start) begin
      left_r <= {edges, 1'b0};
      ph_r <= 1'b0;
    end else if (left_r != 9'h000) begin
      ph_r <= !ph_r;
      if (ph_r) begin
        pin <= !pin;
        left_r <= left_r - 9'h001;
      end
    end
  end
  assign busy = (left_r != 9'h000);
endmodule

// file: dv/tb_eight_bit_timer_counter.sv
// Self-checking bench for the 8-bit timer/counter.
// Assumes the timer module and the event source model.
`timescale 1ns/1ps
`include "ett_map.svh"
module tb_eight_bit_timer_counter;
  import ett_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = '0;
  logic [31:0] dat = '0;
  logic [31:0] rdat;
  logic we = 1'b0;
  logic [3:0] sel = '0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack;
  logic cvec = 1'b0;
  logic ovec = 1'b0;
  logic pin, oe, cirq, oirq, ext_pin, src_busy;
  logic src_go = 1'b0;
  logic [7:0] src_n = '0;
  logic [7:0] q, v;
  int errors = 0;
  int total_checks = 0;

  always #4 clk = !clk;

  ett_timer DUT (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .ext_count_pin(ext_pin), .cmp_vector_taken(cvec), .ovf_vector_taken(ovec),
    .waveform_out_pin(pin), .waveform_out_oe(oe), .compare_irq(cirq), .overflow_irq(oirq));
  ett_event_src SRC (.clk(clk), .rst_n(rst_n), .start(src_go), .edges(src_n), .pin(ext_pin),
    .busy(src_busy));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      final_report();
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(name, r & m, exp);
  endtask

  task automatic ext_count(input logic [7:0] cs);
    int n;
    wr(`ETT_OFF_CTRL, 8'h00);
    wr(`ETT_OFF_CNT, 8'h00);
    wr(`ETT_OFF_CTRL, cs);
    v = 8'($urandom_range(20, 1));
    @(posedge clk);
    src_go <= 1'b1;
    src_n <= v;
    @(posedge clk);
    src_go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (src_busy !== 1'b0 && n < 200);
    repeat (4) @(posedge clk);
    rd_chk("ext count", `ETT_OFF_CNT, 8'hFF, v);
  endtask

  task automatic duty(input logic [7:0] c, input logic [7:0] ctl, input int win, input int lo, input int hi);
    int h;
    h = 0;
    wr(`ETT_OFF_CMP, c);
    wr(`ETT_OFF_CTRL, ctl);
    repeat (600) @(posedge clk);
    repeat (win) begin
      @(posedge clk);
      if (pin === 1'b1) h++;
    end
    chk("pwm duty", 8'(h >= lo && h <= hi), 8'h01);
  endtask

  task automatic presc(input logic [7:0] cs, input int win, input int lo, input int hi);
    wr(`ETT_OFF_CTRL, 8'h00);
    wr(`ETT_OFF_CNT, 8'h00);
    wr(`ETT_OFF_CTRL, cs);
    repeat (win) @(posedge clk);
    wr(`ETT_OFF_CTRL, 8'h00);
    bus(1'b0, `ETT_OFF_CNT, 8'h00, q);
    chk("prescaled count", 8'(q >= lo && q <= hi), 8'h01);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(70));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk("reset value", 8'(i * 4), 8'hFF, 8'h00);
    end
    v = 8'($urandom);
    wr(`ETT_OFF_CNT, v);
    rd_chk("counter", `ETT_OFF_CNT, 8'hFF, v);
    v = 8'($urandom);
    wr(`ETT_OFF_CMP, v);
    rd_chk("compare", `ETT_OFF_CMP, 8'hFF, v);
    wr(`ETT_OFF_PORT, 8'h05);
    wr(`ETT_OFF_MASK, 8'h03);
    rd_chk("mask", `ETT_OFF_MASK, 8'hFF, 8'h03);
    chk("pin enable", oe, 8'h01);
    chk("port pin", pin, 8'h00);
    // Forced compare in normal mode
    wr(`ETT_OFF_CTRL, 8'h90);
    rd_chk("ctrl readback", `ETT_OFF_CTRL, 8'hFF, 8'h10);
    chk("force toggle", pin, 8'h01);
    wr(`ETT_OFF_CTRL, 8'h90);
    chk("force toggle", pin, 8'h00);
    wr(`ETT_OFF_CTRL, 8'hB0);
    chk("force set", pin, 8'h01);
    wr(`ETT_OFF_CTRL, 8'hA0);
    chk("force clear", pin, 8'h00);
    rd_chk("force flags", `ETT_OFF_FLAGS, 8'hFF, 8'h00);
    wr(`ETT_OFF_CTRL, 8'hF8);
    chk("force in pwm", pin, 8'h00);
    rd_chk("mode readback", `ETT_OFF_CTRL, 8'hFF, 8'h78);
    ext_count(8'h07);
    ext_count(8'h06);
    // Normal mode overflow and its vector
    wr(`ETT_OFF_CTRL, 8'h00);
    wr(`ETT_OFF_CNT, 8'hF0);
    wr(`ETT_OFF_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    wr(`ETT_OFF_CTRL, 8'h00);
    rd_chk("overflow flag", `ETT_OFF_FLAGS, 8'h01, 8'h01);
    chk("overflow irq", oirq, 8'h01);
    @(posedge clk);
    ovec <= 1'b1;
    @(posedge clk);
    ovec <= 1'b0;
    @(posedge clk);
    chk("overflow vector", oirq, 8'h00);
    // Clear-on-match counting
    wr(`ETT_OFF_FLAGS, 8'h03);
    wr(`ETT_OFF_CMP, 8'h10);
    wr(`ETT_OFF_CNT, 8'h00);
    wr(`ETT_OFF_CTRL, 8'h09);
    repeat (100) @(posedge clk);
    wr(`ETT_OFF_CTRL, 8'h08);
    bus(1'b0, `ETT_OFF_CNT, 8'h00, q);
    chk("clear top", 8'(q <= 8'h10), 8'h01);
    rd_chk("clear flags", `ETT_OFF_FLAGS, 8'h03, 8'h02);
    chk("compare irq", cirq, 8'h01);
    wr(`ETT_OFF_FLAGS, 8'h02);
    chk("flag write one", cirq, 8'h00);
    presc(8'h02, 80, 10, 11);
    presc(8'h03, 637, 10, 10);
    presc(8'h04, 2557, 10, 10);
    presc(8'h05, 1021, 1, 1);
    duty(8'h80, 8'h69, 256, 127, 131);
    duty(8'h40, 8'h61, 510, 124, 132);
    wr(`ETT_OFF_FLAGS, 8'h01);
    repeat (520) @(posedge clk);
    rd_chk("phase overflow", `ETT_OFF_FLAGS, 8'h01, 8'h01);
    duty(8'h40, 8'h71, 510, 378, 386);
    duty(8'hFF, 8'h69, 256, 256, 256);
    duty(8'hFF, 8'h61, 510, 510, 510);
    final_report();
  end
endmodule
